// ### shared/adc_pkg.sv
// constants, field layout and types of the converter sequencer
package adc_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int RES_W = 10;
  localparam int RES_PAD_W = 6;
  localparam int CHAN_W = 3;
  localparam int CHAN_N = 8;
  localparam int STAT_W = 2;

  // byte offsets of the register words
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CHAN = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;

  // mode register fields
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_SRC_BIT = 6;
  localparam int MODE_TIME_LSB = 3;
  localparam int MODE_EDGE_LSB = 1;
  localparam int MODE_BOOST_BIT = 0;

  // interrupt status fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_MISS_BIT = 1;

  // state register fields
  localparam int STATE_BUSY_BIT = 0;
  localparam int STATE_SAMPLE_BIT = 1;
  localparam int STATE_CHAN_LSB = 2;
  localparam int STATE_TRIG_BIT = 5;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [2:0] CHAN_RST = 3'h0;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // edge codes
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;

  // conversion = 2 sampling steps + 10 bit steps, each step_len clocks
  localparam logic [3:0] SAMPLE_STEPS = 4'h2;
  localparam logic [3:0] STEP_144 = 4'hc;
  localparam logic [3:0] STEP_120 = 4'ha;
  localparam logic [3:0] STEP_96 = 4'h8;
  localparam logic [3:0] STEP_72 = 4'h6;
  localparam logic [3:0] STEP_60 = 4'h5;
  localparam logic [3:0] STEP_48 = 4'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    CORE_IDLE = 2'b00,
    CORE_SAMPLE = 2'b01,
    CORE_CONVERT = 2'b10
  } core_state_type;

  typedef enum logic [2:0]
  {
    SEL_MODE = 3'b000,
    SEL_CHAN = 3'b001,
    SEL_RESULT = 3'b010,
    SEL_STATUS = 3'b011,
    SEL_MASK = 3'b100,
    SEL_STATE = 3'b101,
    SEL_NONE = 3'b111
  } reg_sel_type;
endpackage

// ### shared/sar_link_if.sv
// link between register control and the approximation core
interface sar_link_if;
  logic start;
  logic enable;
  logic taken;
  logic [3:0] step_len;
  logic busy;
  logic sampling;
  logic done;
  logic [adc_pkg::RES_W-1:0] result;
  logic [adc_pkg::RES_W-1:0] trial;
  logic comp_hi;

  modport ctl
  (
    output start,
    output enable,
    output step_len,
    output comp_hi,
    input taken,
    input busy,
    input sampling,
    input done,
    input result,
    input trial
  );

  modport core
  (
    input start,
    input enable,
    input step_len,
    input comp_hi,
    output taken,
    output busy,
    output sampling,
    output done,
    output result,
    output trial
  );
endinterface

// ### verilog/sar_core.sv
// sample phase and bit-by-bit approximation with result register
module sar_core
(
  input wire logic aclk,
  input wire logic aresetn,
  sar_link_if.core link
);
  typedef struct packed
  {
    adc_pkg::core_state_type state;
    logic [4:0] cnt;
    logic [3:0] step;
    logic [3:0] bit_idx;
    logic [adc_pkg::RES_W-1:0] approx;
    logic [adc_pkg::RES_W-1:0] result;
    logic done;
  } core_type;

  core_type q;
  core_type d;
  logic last;
  logic [adc_pkg::RES_W-1:0] cur;
  logic [adc_pkg::RES_W-1:0] decided;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    cur = adc_pkg::RES_W'(1) << q.bit_idx;
    decided = link.comp_hi ? q.approx : (q.approx & ~cur);
    last = (q.state == adc_pkg::CORE_CONVERT) && (q.cnt == 5'h00) && (q.bit_idx == 4'h0);
    link.taken = link.start && link.enable && ((q.state == adc_pkg::CORE_IDLE) || last);
    case (q.state)
      adc_pkg::CORE_IDLE:
      begin
        d.cnt = 5'h00;
      end
      adc_pkg::CORE_SAMPLE:
      begin
        if (q.cnt == 5'h00)
        begin
          d.state = adc_pkg::CORE_CONVERT;
          d.cnt = 5'(q.step - 4'h1);
          d.bit_idx = 4'(adc_pkg::RES_W - 1);
          d.approx = adc_pkg::RES_W'(1) << (adc_pkg::RES_W - 1); // msb tried first
        end
        else
        begin
          d.cnt = q.cnt - 5'h01;
        end
      end
      adc_pkg::CORE_CONVERT:
      begin
        if (q.cnt == 5'h00)
        begin
          if (q.bit_idx == 4'h0)
          begin
            d.result = decided; // copied after the lsb is decided
            d.done = 1'b1;
            d.state = adc_pkg::CORE_IDLE;
            d.approx = '0;
          end
          else
          begin
            d.approx = decided | (cur >> 1); // next lower bit on trial
            d.bit_idx = q.bit_idx - 4'h1;
            d.cnt = 5'(q.step - 4'h1);
          end
        end
        else
        begin
          d.cnt = q.cnt - 5'h01;
        end
      end
      default:
      begin
        d.state = adc_pkg::CORE_IDLE;
      end
    endcase
    if (link.taken)
    begin
      d.state = adc_pkg::CORE_SAMPLE;
      d.step = link.step_len; // latched so a conversion has fixed length
      d.cnt = 5'((link.step_len * adc_pkg::SAMPLE_STEPS) - 8'h01);
      d.approx = '0;
    end
    if (!link.enable)
    begin
      d.state = adc_pkg::CORE_IDLE; // stop drops the conversion in flight
      d.approx = '0;
      d.done = 1'b0;
    end
    link.busy = q.state != adc_pkg::CORE_IDLE;
    link.sampling = q.state == adc_pkg::CORE_SAMPLE; // hold once sampling ends
    link.done = q.done;
    link.result = q.result;
    link.trial = q.approx;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
endmodule

// ### verilog/sar_adc_sequencer.sv
// register control, trigger and interrupt logic of the converter
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
module sar_adc_sequencer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [adc_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [adc_pkg::AXI_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [adc_pkg::AXI_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [adc_pkg::AXI_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  input wire logic ext_trigger_in,
  input wire logic comp_hi,
  output logic [adc_pkg::RES_W-1:0] dac_code,
  output logic track_en,
  output logic [adc_pkg::CHAN_N-1:0] analog_route,
  output logic [adc_pkg::CHAN_N-1:0] digital_in_en,
  output logic ref_boost_en,
  output logic irq
);
  typedef struct packed
  {
    logic [7:0] mode;
    logic [adc_pkg::CHAN_W-1:0] chan;
    logic [adc_pkg::CHAN_W-1:0] active_chan;
    logic [adc_pkg::CHAN_N-1:0] route;
    logic [adc_pkg::STAT_W-1:0] status;
    logic [adc_pkg::STAT_W-1:0] mask;
    logic [2:0] trig_sync;
    logic trig_level;
    logic aw_have;
    logic [adc_pkg::AXI_ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [adc_pkg::AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } ctl_type;

  ctl_type q;
  ctl_type d;
  sar_link_if link ();

  // address decode, shared by the read and write paths
  function automatic adc_pkg::reg_sel_type reg_sel(input logic [adc_pkg::AXI_ADDR_W-1:0] addr);
    logic [7:0] word;
    word = {addr[7:2], 2'b00};
    case (word)
      adc_pkg::OFS_MODE: reg_sel = adc_pkg::SEL_MODE;
      adc_pkg::OFS_CHAN: reg_sel = adc_pkg::SEL_CHAN;
      adc_pkg::OFS_RESULT: reg_sel = adc_pkg::SEL_RESULT;
      adc_pkg::OFS_STATUS: reg_sel = adc_pkg::SEL_STATUS;
      adc_pkg::OFS_MASK: reg_sel = adc_pkg::SEL_MASK;
      adc_pkg::OFS_STATE: reg_sel = adc_pkg::SEL_STATE;
      default: reg_sel = adc_pkg::SEL_NONE;
    endcase
  endfunction

  // conversion time code to clocks per step; twelve steps per conversion
  function automatic logic [3:0] step_of(input logic [2:0] code);
    case (code)
      3'h0: step_of = adc_pkg::STEP_144;
      3'h1: step_of = adc_pkg::STEP_120;
      3'h2: step_of = adc_pkg::STEP_96;
      3'h4: step_of = adc_pkg::STEP_72;
      3'h5: step_of = adc_pkg::STEP_60;
      3'h6: step_of = adc_pkg::STEP_48;
      // prohibited codes fall back to the slowest, safest timing
      default: step_of = adc_pkg::STEP_144;
    endcase
  endfunction

  sar_core sar_core_i
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .link(link)
  );

  logic enabled;
  logic hw_start;
  logic [1:0] edge_sel;
  logic change;
  logic rise;
  logic fall;
  logic hit;
  logic miss;
  logic wr_fire;
  logic ar_fire;
  adc_pkg::reg_sel_type wsel;
  adc_pkg::reg_sel_type rsel;
  logic [adc_pkg::STAT_W-1:0] clr;
  logic [adc_pkg::STAT_W-1:0] events;

  always_comb
  begin
    d = q;
    enabled = q.mode[adc_pkg::MODE_EN_BIT]; // enable bit starts and stops
    hw_start = q.mode[adc_pkg::MODE_SRC_BIT]; // 1 picks trigger start
    edge_sel = q.mode[adc_pkg::MODE_EDGE_LSB +: 2];

    // trigger pin: three stages, change counted once stages two and three agree
    d.trig_sync = {q.trig_sync[1:0], ext_trigger_in};
    change = (q.trig_sync[1] == q.trig_sync[2]) && (q.trig_sync[2] != q.trig_level);
    if (change)
    begin
      d.trig_level = q.trig_sync[2];
    end
    rise = change && q.trig_sync[2];
    fall = change && !q.trig_sync[2];
    hit = (edge_sel[1] && rise) || (edge_sel[0] && fall); // edge code decode

    // software mode asks continuously, so the core restarts on its last step
    link.enable = enabled; // disabled: no start, conversion dropped
    link.start = enabled && (hw_start ? hit : 1'b1);
    // hardware mode asks only on an edge, so it stops after one result
    link.step_len = step_of(q.mode[adc_pkg::MODE_TIME_LSB +: 3]);
    // comparator answer is on this clock already, so no synchroniser
    link.comp_hi = comp_hi;
    // an edge refused while busy is flagged in status, not queued
    miss = enabled && hw_start && hit && !link.taken;

    // channel of the conversion kept for the state register
    if (link.taken)
    begin
      d.active_chan = q.chan; // one channel per conversion
    end
    d.route = adc_pkg::CHAN_N'(1) << q.chan; // only the selected pin routed

    // write address and data are taken independently, in either order
    if (awvalid && !q.aw_have)
    begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && !q.w_have)
    begin
      d.w_have = 1'b1;
      d.w_data = wdata[7:0];
      d.w_lane0 = wstrb[0];
    end
    // no queue: one write answer outstanding at most
    wr_fire = q.aw_have && q.w_have && !q.bvalid;
    wsel = reg_sel(q.aw_addr);
    clr = '0;
    if (wr_fire)
    begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (wsel == adc_pkg::SEL_NONE) ? adc_pkg::RESP_SLVERR : adc_pkg::RESP_OKAY;
      // only lane 0 carries register bits; other lanes are ignored
      if (q.w_lane0)
      begin
        case (wsel)
          adc_pkg::SEL_MODE:
          begin
            d.mode = q.w_data;
          end
          adc_pkg::SEL_CHAN:
          begin
            d.chan = q.w_data[adc_pkg::CHAN_W-1:0]; // upper bits not stored
          end
          adc_pkg::SEL_STATUS:
          begin
            clr = q.w_data[adc_pkg::STAT_W-1:0];
          end
          adc_pkg::SEL_MASK:
          begin
            d.mask = q.w_data[adc_pkg::STAT_W-1:0];
          end
          default:
          begin
            clr = '0;
          end
        endcase
      end
    end
    // response stands until the master takes it
    if (q.bvalid && bready)
    begin
      d.bvalid = 1'b0;
    end

    // sticky events; a set in the clearing cycle wins
    events = '0;
    events[adc_pkg::STAT_DONE_BIT] = link.done; // every completion, both modes
    events[adc_pkg::STAT_MISS_BIT] = miss;
    d.status = (q.status & ~clr) | events;

    // read data registered; arready drops while an answer waits
    ar_fire = arvalid && !q.rvalid;
    rsel = reg_sel(araddr);
    if (ar_fire)
    begin
      d.rvalid = 1'b1;
      d.rresp = adc_pkg::RESP_OKAY;
      d.rdata = '0;
      case (rsel)
        adc_pkg::SEL_MODE:
        begin
          d.rdata[7:0] = q.mode;
        end
        adc_pkg::SEL_CHAN:
        begin
          d.rdata[adc_pkg::CHAN_W-1:0] = q.chan;
        end
        adc_pkg::SEL_RESULT:
        begin
          // value in the upper ten bits, low six fixed at zero
          d.rdata[15:0] = {link.result, adc_pkg::RES_PAD_W'(0)};
        end
        adc_pkg::SEL_STATUS:
        begin
          d.rdata[adc_pkg::STAT_W-1:0] = q.status;
        end
        adc_pkg::SEL_MASK:
        begin
          d.rdata[adc_pkg::STAT_W-1:0] = q.mask;
        end
        adc_pkg::SEL_STATE:
        begin
          d.rdata[adc_pkg::STATE_BUSY_BIT] = link.busy;
          d.rdata[adc_pkg::STATE_SAMPLE_BIT] = link.sampling;
          d.rdata[adc_pkg::STATE_CHAN_LSB +: adc_pkg::CHAN_W] = q.active_chan;
          d.rdata[adc_pkg::STATE_TRIG_BIT] = q.trig_level;
        end
        default:
        begin
          d.rresp = adc_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (q.rvalid && rready)
    begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // pin 0 is selected out of reset, so its route is up at once
      q <= '{route: adc_pkg::CHAN_N'(1), default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  // readies come straight from the holding flags
  assign awready = !q.aw_have;
  assign wready = !q.w_have;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = !q.rvalid;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign dac_code = link.trial; // msb-first trial code to the resistor string
  assign track_en = link.sampling; // low means hold
  assign analog_route = q.route;
  assign digital_in_en = ~q.route;
  assign ref_boost_en = q.mode[adc_pkg::MODE_BOOST_BIT];
  // interrupt is a level while any unmasked sticky bit is set
  assign irq = |(q.status & q.mask);
endmodule

// ### testbench/sar_adc_checker_properties.sv
// port assertions of the converter sequencer
module sar_adc_checker
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic bvalid,
  input wire logic [9:0] dac_code,
  input wire logic track_en,
  input wire logic [7:0] analog_route,
  input wire logic [7:0] digital_in_en,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] low_bit;
  assign low_bit = dac_code & (~dac_code + 10'h001);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_hold;
    (track_en && dac_code == 10'h000) [*8];
  endsequence
  sequence s_first;
    !track_en && dac_code == 10'h200;
  endsequence
  property p_sample_hold;
    $rose(track_en) |-> s_hold;
  endproperty
  property p_first_trial;
    $fell(track_en) |-> s_first;
  endproperty
  // trial bit walks down one place per step
  property p_step_down;
    $changed(dac_code) && $past(dac_code) != 10'h000 && dac_code != 10'h000
      |-> low_bit == $past(low_bit) >> 1;
  endproperty
  property p_one_route;
    $onehot(analog_route);
  endproperty
  property p_pins_digital;
    digital_in_en == ~analog_route;
  endproperty
  property p_read_next;
    arvalid && arready |=> rvalid;
  endproperty
  property p_read_refuse;
    rvalid |-> !arready;
  endproperty
  property p_irq_clear;
    $fell(irq) |-> $rose(bvalid);
  endproperty
  a_sample_hold: assert property (p_sample_hold) else $error("sample cut short");
  a_first_trial: assert property (p_first_trial) else $error("first trial not msb");
  a_step_down: assert property (p_step_down) else $error("trial order broken");
  a_one_route: assert property (p_one_route) else $error("route not one-hot");
  a_pins_digital: assert property (p_pins_digital) else $error("pin mode wrong");
  a_read_next: assert property (p_read_next) else $error("read answer late");
  a_read_refuse: assert property (p_read_refuse) else $error("read not held off");
  a_irq_clear: assert property (p_irq_clear) else $error("irq fell unasked");
endmodule

bind sar_adc_sequencer sar_adc_checker sar_adc_checker_i
(
  .aclk(aclk),
  .aresetn(aresetn),
  .arvalid(arvalid),
  .arready(arready),
  .rvalid(rvalid),
  .bvalid(bvalid),
  .dac_code(dac_code),
  .track_en(track_en),
  .analog_route(analog_route),
  .digital_in_en(digital_in_en),
  .irq(irq)
);

// ### testbench/analog_source.sv
// analog inputs with sample and hold and comparator
module analog_source
(
  input wire logic aclk,
  input wire logic [79:0] levels,
  input wire logic track_en,
  input wire logic [7:0] analog_route,
  input wire logic [9:0] dac_code,
  output logic comp_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] pick;
  logic [9:0] held = 10'h000;
  always_comb
  begin
    pick = 10'h155; // a bad route gives junk, not a kind value
    for (int c = 0; c < 8; c++)
      if (analog_route == (8'h01 << c)) pick = levels[c*10 +: 10];
  end
  always_ff @(posedge aclk)
    if (track_en) held <= pick;
  assign comp_hi = held >= dac_code;
endmodule

// ### testbench/sar_adc_sequencer_bench.sv
// self-checking bench of the converter sequencer
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module sar_adc_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, analog_route, digital_in_en;
  logic [31:0] wdata, rdata, data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic ext_trigger_in, comp_hi, track_en, ref_boost_en, irq, seen;
  logic [9:0] dac_code;
  // ch7 first down to ch0
  logic [79:0] levels = {10'h3c1, 10'h04e, 10'h2b6, 10'h1a7, 10'h3ff, 10'h0d9, 10'h255, 10'h001};
  int bad_count = 0;
  int n_checks = 0;
  int cnt;
  sar_adc_sequencer sar_adc_sequencer_i
  (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .ext_trigger_in(ext_trigger_in), .comp_hi(comp_hi),
    .dac_code(dac_code), .track_en(track_en), .analog_route(analog_route),
    .digital_in_en(digital_in_en), .ref_boost_en(ref_boost_en), .irq(irq)
  );
  analog_source analog_source_i
  (
    .aclk(aclk), .levels(levels), .track_en(track_en), .analog_route(analog_route),
    .dac_code(dac_code), .comp_hi(comp_hi)
  );
  initial
  begin
    forever #10 aclk = ~aclk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang;
    `CHK("wait", 1'b1, 1'b0)
    give_verdict;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic fin;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fin = 1'b0;
    for (int n = 0; n < 50 && !fin; n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        fin = 1'b1;
      end
    end
    if (!fin) hang;
  endtask
  task automatic rd(input logic [7:0] a);
    logic fin;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    fin = 1'b0;
    for (int n = 0; n < 50 && !fin; n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
        fin = 1'b1;
      end
    end
    if (!fin) hang;
  endtask
  task automatic wait_irq(input int lim);
    seen = 1'b0;
    for (int n = 0; n < lim && !seen; n++)
    begin
      @(posedge aclk);
      seen = irq;
    end
  endtask
  task automatic wait_track(input logic lvl);
    cnt = 0;
    while (track_en !== lvl && cnt < 300)
    begin
      @(posedge aclk);
      cnt++;
    end
    if (cnt == 300) hang;
  endtask
  task automatic t_reset;
    rd(adc_pkg::OFS_RESULT);
    `CHK("result", 32'h0, data)
    `CHK("route", 8'h01, analog_route)
    `CHK("irq", 1'b0, irq)
    rd(8'h40);
    `CHK("rresp", adc_pkg::RESP_SLVERR, resp)
    wr(8'h40, 32'h0);
    `CHK("bresp", adc_pkg::RESP_SLVERR, resp)
    $display("test reset done");
  endtask
  task automatic t_soft;
    int codes[8] = '{0, 1, 2, 4, 5, 6, 3, 7};
    int steps[8] = '{12, 10, 8, 6, 5, 4, 12, 12};
    wr(adc_pkg::OFS_CHAN, 32'h5);
    wr(adc_pkg::OFS_MODE, 32'hb0);
    `CHK("route", 8'h20, analog_route)
    wait_irq(150);
    `CHK("masked irq", 1'b0, seen)
    wr(adc_pkg::OFS_MASK, 32'h1);
    `CHK("irq", 1'b1, irq)
    rd(adc_pkg::OFS_RESULT);
    `CHK("result", {16'h0, 10'h2b6, 6'h00}, data)
    wr(adc_pkg::OFS_STATUS, 32'h1);
    wait_irq(60);
    `CHK("repeat irq", 1'b1, seen)
    // time is latched at start, so judge the conversion after the one under way
    for (int k = 0; k < 8; k++)
    begin
      wr(adc_pkg::OFS_MODE, 32'h80 | (codes[k] << 3));
      wait_track(1'b0);
      wait_track(1'b1);
      wait_track(1'b0);
      `CHK("sample len", 2 * steps[k], cnt)
      wait_track(1'b1);
      `CHK("bit len", 10 * steps[k], cnt)
    end
    $display("test software start done");
  endtask
  task automatic t_off;
    logic [31:0] r0;
    wait_track(1'b0);
    wr(adc_pkg::OFS_MODE, 32'h44);
    rd(adc_pkg::OFS_RESULT);
    r0 = data;
    repeat (2)
    begin
      @(posedge aclk);
      ext_trigger_in <= ~ext_trigger_in;
      repeat (20) @(posedge aclk);
    end
    `CHK("track off", 1'b0, track_en)
    rd(adc_pkg::OFS_RESULT);
    `CHK("kept result", r0, data)
    $display("test disabled done");
  endtask
  task automatic t_hw;
    logic [1:0] edges[4] = '{2'h2, 2'h1, 2'h0, 2'h3};
    wr(adc_pkg::OFS_CHAN, 32'h2);
    for (int k = 0; k < 4; k++)
    begin
      wr(adc_pkg::OFS_STATUS, 32'h3);
      wr(adc_pkg::OFS_MODE, {24'h0, 2'b11, 3'h6, edges[k], 1'b1});
      `CHK("boost", 1'b1, ref_boost_en)
      @(posedge aclk);
      ext_trigger_in <= ~ext_trigger_in;
      wait_irq(100);
      `CHK("hw start", edges[k] != 2'h0, seen)
      if (seen)
      begin
        rd(adc_pkg::OFS_RESULT);
        `CHK("hw result", {16'h0, 10'h0d9, 6'h00}, data)
        cnt = 0;
        repeat (60)
        begin
          @(posedge aclk);
          cnt += track_en;
        end
        `CHK("stopped", 0, cnt)
        rd(adc_pkg::OFS_STATE);
        `CHK("state", {26'h0, ext_trigger_in, 3'h2, 2'b00}, data)
      end
    end
    // second edge lands while busy: dropped and flagged, first result still done
    wr(adc_pkg::OFS_STATUS, 32'h3);
    @(posedge aclk);
    ext_trigger_in <= ~ext_trigger_in;
    repeat (20) @(posedge aclk);
    ext_trigger_in <= ~ext_trigger_in;
    wait_irq(100);
    `CHK("busy irq", 1'b1, seen)
    rd(adc_pkg::OFS_STATUS);
    `CHK("missed edge", 32'h3, data)
    $display("test hardware start done");
  endtask
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, ext_trigger_in} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_soft;
    t_off;
    t_hw;
    give_verdict;
  end
endmodule
